// File: hw/cpu_exec_pkg.sv
// Constants, types and op codes shared by the bit/flag/io execution unit.
// Assumes a decoder that hands over one pre-decoded op per issue handshake.
//
// Function
// - io read copies io location to register, io write the reverse; one cycle.
// - push writes register to stack in two cycles, flags untouched.
// - pop reads stack into register in two cycles, flags untouched.
// - exchange swaps register with byte at Z; load-or writes register OR byte.
// - load-clearbits loads byte, writes byte AND complement of register; three cycles.
// - load-xor loads byte, writes byte XOR register; three cycles, no flags.
// - left shifts put bit7 in carry, fill 0 or carry; update Z,C,N,V,H.
// - right shifts put bit0 in carry; bit7 zero, carry or kept; update Z,C,N,V.
// - generic and dedicated opcodes set or clear one status flag in one cycle.
// - signed-test flag has its own set and clear opcodes, single cycle.
// - half-carry and transfer flags have own set and clear opcodes.
// - io bit-force-one sets one selected bit of io register, one cycle.
// - io bit-force-zero clears one selected bit of io register, one cycle.
// - selected register bit copied into transfer flag only, one cycle.
// - transfer flag copied into selected register bit, one cycle.
// - watchdog restart issues in one cycle and requests watchdog unit.
// - sleep hands request to sleep control in one cycle; nop one cycle.
// - break decodes in one cycle and signals debug logic.
// - memory cycle counts hold for internal memory; external may stall longer.
// - marked data reads from internal SRAM take one extra cycle.

package cpu_exec_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFF   = 8'h00;
  localparam logic [7:0]  SP_OFF     = 8'h04;
  localparam logic [7:0]  FLAGS_OFF  = 8'h08;
  localparam logic [7:0]  STATE_OFF  = 8'h0c;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic        CTRL_EN_RST = 1'b1;
  localparam logic [15:0] SP_RST      = 16'h0fff;
  localparam logic [7:0]  FLAGS_RST   = 8'h00;

  // ----------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ----------------------------------------------------------------
  // Pre-decoded ops
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    op_nop = 6'h00, op_io_read = 6'h01, op_io_write = 6'h02,
    op_push = 6'h03, op_pop = 6'h04,
    op_ram_exchange_op = 6'h05, op_ram_load_or_op = 6'h06,
    op_ram_load_clearbits_op = 6'h07, op_ram_load_xor_op = 6'h08,
    op_shift_left_logical = 6'h09, op_shift_right_logical = 6'h0a,
    op_carry_rotate_left = 6'h0b, op_carry_rotate_right = 6'h0c,
    op_shift_right_signed = 6'h0d,
    op_flag_select_set = 6'h0e, op_flag_select_clear = 6'h0f,
    op_io_bit_force_one = 6'h10, op_io_bit_force_zero = 6'h11,
    op_reg_bit_to_tflag = 6'h12, op_tflag_to_reg_bit = 6'h13,
    op_carry_flag_on = 6'h14, op_carry_flag_off = 6'h15,
    op_negative_flag_on = 6'h16, op_negative_flag_off = 6'h17,
    op_zero_flag_on = 6'h18, op_zero_flag_off = 6'h19,
    op_global_irq_on = 6'h1a, op_global_irq_off = 6'h1b,
    op_signed_flag_on = 6'h1c, op_signed_flag_off = 6'h1d,
    op_overflow_flag_on = 6'h1e, op_overflow_flag_off = 6'h1f,
    op_transfer_flag_on = 6'h20, op_transfer_flag_off = 6'h21,
    op_half_carry_on = 6'h22, op_half_carry_off = 6'h23,
    op_sleep = 6'h24, op_break = 6'h25, op_watchdog_restart_op = 6'h26
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10,
    ST_EXTRA = 2'b11
  } state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    op_t        op;
    logic [4:0] reg_idx;
    logic [5:0] io_addr;
    logic [2:0] bit_sel;
    logic       sram_extra;
  } issue_t;

  typedef struct packed {
    logic       req;
    logic       we;
    logic       lock;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dmem_req_t;

  typedef struct packed {
    logic       we;
    logic [5:0] addr;
    logic [7:0] data;
  } io_wr_t;

  typedef struct packed {
    logic       we;
    logic [4:0] addr;
    logic [7:0] data;
  } rf_wr_t;

  typedef struct packed {
    op_t        op;
    logic [4:0] reg_idx;
    logic [7:0] temp;
    logic [7:0] mem_byte;
    logic       extra;
  } hold_t;

endpackage

// File: hw/cpu_io_bit_flag_exec.sv
// Execution unit for io moves, stack, atomic RAM ops, shifts, bit/flag ops and
// control ops, with a classic Wishbone slave for control and observation.
// Assumes combinational register-file and io reads, and a data memory that
// answers each request with dmem_ack_i, at the earliest in the same cycle.
`timescale 1ns/1ps

module cpu_io_bit_flag_exec #(
  parameter int unsigned          WB_ADR_W      = 8,
  parameter logic [15:0]          INT_SRAM_LAST = 16'h3fff
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Issue from decode
  input  wire logic                    issue_valid_i,
  input  wire cpu_exec_pkg::issue_t    issue_i,
  output logic                         issue_ready_o,
  output logic                         done_o,
  // Register file
  output logic [4:0]                   rf_raddr_o,
  input  wire logic [7:0]              rf_rdata_i,
  output cpu_exec_pkg::rf_wr_t         rf_wr_o,
  // Io space
  output logic [5:0]                   io_raddr_o,
  input  wire logic [7:0]              io_rdata_i,
  output cpu_exec_pkg::io_wr_t         io_wr_o,
  // Data memory and stack
  input  wire logic [15:0]             z_ptr_i,
  output cpu_exec_pkg::dmem_req_t      dmem_o,
  input  wire logic                    dmem_ack_i,
  input  wire logic [7:0]              dmem_rdata_i,
  // Status flags and control requests
  output logic [7:0]                   status_flags_o,
  output logic                         sleep_req_o,
  output logic                         break_req_o,
  output logic                         wdt_restart_o,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [WB_ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic [31:0]                  wb_dat_o,
  output logic                         wb_ack_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (WB_ADR_W < 4 || WB_ADR_W > 16) begin : g_bad_adr
    $error("WB_ADR_W must lie between 4 and 16");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cpu_exec_pkg::state_t    state_q, state_d;
  cpu_exec_pkg::hold_t     hold_q, hold_d;
  cpu_exec_pkg::dmem_req_t dmem_q, dmem_d;
  cpu_exec_pkg::io_wr_t    io_q, io_d;
  cpu_exec_pkg::rf_wr_t    rf_q, rf_d;
  logic [15:0]             sp_q, sp_d;
  logic [7:0]              flags_q, flags_d;
  logic                    done_q, done_d;
  logic                    sleep_q, sleep_d;
  logic                    brk_q, brk_d;
  logic                    wdt_q, wdt_d;
  logic                    en_q;
  logic                    ack_q;
  logic [31:0]             rdat_q;

  // ----------------------------------------------------------------
  // Issue handshake and operand routing
  // ----------------------------------------------------------------
  // A write in flight may retire in the same cycle a new op is taken
  wire write_retiring = (state_q == cpu_exec_pkg::ST_WRITE) & dmem_ack_i;
  wire slot_free      = (state_q == cpu_exec_pkg::ST_IDLE) | write_retiring;
  wire issue_fire     = issue_valid_i & issue_ready_o;
  wire [7:0] bit_mask = 8'h01 << issue_i.bit_sel;
  wire [7:0] reg_val  = rf_rdata_i;
  wire [7:0] io_val   = io_rdata_i;

  assign issue_ready_o = en_q & slot_free;
  assign rf_raddr_o    = issue_i.reg_idx;
  assign io_raddr_o    = issue_i.io_addr;

  // ----------------------------------------------------------------
  // Memory read completion
  // ----------------------------------------------------------------
  // Internal SRAM reads flagged by decode get one more cycle
  wire addr_internal = dmem_q.addr <= INT_SRAM_LAST;
  wire need_extra    = hold_q.extra & addr_internal;
  wire read_ack      = (state_q == cpu_exec_pkg::ST_READ) & dmem_ack_i;
  wire read_finish   = (read_ack & ~need_extra) | (state_q == cpu_exec_pkg::ST_EXTRA);
  wire [7:0] mem_val = (state_q == cpu_exec_pkg::ST_EXTRA) ? hold_q.mem_byte : dmem_rdata_i;

  // Write-back value of the atomic ops, from old register and old byte
  logic [7:0] rmw_val;
  always_comb begin
    unique case (hold_q.op)
      cpu_exec_pkg::op_ram_exchange_op:       rmw_val = hold_q.temp;
      cpu_exec_pkg::op_ram_load_or_op:        rmw_val = hold_q.temp | mem_val;
      cpu_exec_pkg::op_ram_load_clearbits_op: rmw_val = ~hold_q.temp & mem_val;
      cpu_exec_pkg::op_ram_load_xor_op:       rmw_val = hold_q.temp ^ mem_val;
      default:                                rmw_val = mem_val;
    endcase
  end

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  logic [7:0] sh_res;
  logic       sh_c;
  logic       sh_left;
  always_comb begin
    sh_left = 1'b0;
    sh_c    = reg_val[0];
    unique case (issue_i.op)
      cpu_exec_pkg::op_shift_left_logical: begin
        sh_res  = {reg_val[6:0], 1'b0};
        sh_c    = reg_val[7];
        sh_left = 1'b1;
      end
      cpu_exec_pkg::op_carry_rotate_left: begin
        sh_res  = {reg_val[6:0], flags_q[cpu_exec_pkg::FLAG_C]};
        sh_c    = reg_val[7];
        sh_left = 1'b1;
      end
      cpu_exec_pkg::op_shift_right_logical: sh_res = {1'b0, reg_val[7:1]};
      cpu_exec_pkg::op_carry_rotate_right:
        sh_res = {flags_q[cpu_exec_pkg::FLAG_C], reg_val[7:1]};
      default: sh_res = {reg_val[7], reg_val[7:1]};
    endcase
  end

  // ----------------------------------------------------------------
  // Dedicated flag opcodes mapped onto a flag index and value
  // ----------------------------------------------------------------
  logic       ded_hit;
  logic       ded_val;
  logic [2:0] ded_idx;
  always_comb begin
    ded_hit = 1'b1;
    ded_val = 1'b1;
    ded_idx = cpu_exec_pkg::FLAG_C;
    unique case (issue_i.op)
      cpu_exec_pkg::op_carry_flag_on:     ded_idx = cpu_exec_pkg::FLAG_C;
      cpu_exec_pkg::op_carry_flag_off:    begin ded_idx = cpu_exec_pkg::FLAG_C; ded_val = 1'b0; end
      cpu_exec_pkg::op_negative_flag_on:  ded_idx = cpu_exec_pkg::FLAG_N;
      cpu_exec_pkg::op_negative_flag_off: begin ded_idx = cpu_exec_pkg::FLAG_N; ded_val = 1'b0; end
      cpu_exec_pkg::op_zero_flag_on:      ded_idx = cpu_exec_pkg::FLAG_Z;
      cpu_exec_pkg::op_zero_flag_off:     begin ded_idx = cpu_exec_pkg::FLAG_Z; ded_val = 1'b0; end
      cpu_exec_pkg::op_global_irq_on:     ded_idx = cpu_exec_pkg::FLAG_I;
      cpu_exec_pkg::op_global_irq_off:    begin ded_idx = cpu_exec_pkg::FLAG_I; ded_val = 1'b0; end
      cpu_exec_pkg::op_signed_flag_on:    ded_idx = cpu_exec_pkg::FLAG_S;
      cpu_exec_pkg::op_signed_flag_off:   begin ded_idx = cpu_exec_pkg::FLAG_S; ded_val = 1'b0; end
      cpu_exec_pkg::op_overflow_flag_on:  ded_idx = cpu_exec_pkg::FLAG_V;
      cpu_exec_pkg::op_overflow_flag_off: begin ded_idx = cpu_exec_pkg::FLAG_V; ded_val = 1'b0; end
      cpu_exec_pkg::op_transfer_flag_on:  ded_idx = cpu_exec_pkg::FLAG_T;
      cpu_exec_pkg::op_transfer_flag_off: begin ded_idx = cpu_exec_pkg::FLAG_T; ded_val = 1'b0; end
      cpu_exec_pkg::op_half_carry_on:     ded_idx = cpu_exec_pkg::FLAG_H;
      cpu_exec_pkg::op_half_carry_off:    begin ded_idx = cpu_exec_pkg::FLAG_H; ded_val = 1'b0; end
      default:                            ded_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer: finish outstanding memory work, then take a new op
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    hold_d  = hold_q;
    dmem_d  = dmem_q;
    sp_d    = sp_q;
    flags_d = flags_q;
    io_d    = '0;
    rf_d    = '0;
    done_d  = 1'b0;
    sleep_d = 1'b0;
    brk_d   = 1'b0;
    wdt_d   = 1'b0;
    // Stretch an internal read by one cycle, keeping the byte meanwhile
    if (read_ack && need_extra) begin
      hold_d.mem_byte = dmem_rdata_i;
      dmem_d.req      = 1'b0;
      state_d         = cpu_exec_pkg::ST_EXTRA;
    end
    if (read_finish) begin
      rf_d.we   = 1'b1;
      rf_d.addr = hold_q.reg_idx;
      rf_d.data = mem_val;
      if (hold_q.op == cpu_exec_pkg::op_pop) begin
        dmem_d.req = 1'b0;
        state_d    = cpu_exec_pkg::ST_IDLE;
        done_d     = 1'b1;
      end else begin
        // Lock stays up from the read through the write-back
        dmem_d.req   = 1'b1;
        dmem_d.we    = 1'b1;
        dmem_d.lock  = 1'b1;
        dmem_d.wdata = rmw_val;
        state_d      = cpu_exec_pkg::ST_WRITE;
      end
    end
    if (write_retiring) begin
      dmem_d  = '0;
      state_d = cpu_exec_pkg::ST_IDLE;
      done_d  = 1'b1;
    end
    if (issue_fire) begin
      hold_d.op      = issue_i.op;
      hold_d.reg_idx = issue_i.reg_idx;
      hold_d.temp    = reg_val;
      hold_d.extra   = issue_i.sram_extra;
      done_d         = 1'b1;
      if (ded_hit) begin
        flags_d[ded_idx] = ded_val;
      end
      unique case (issue_i.op)
        cpu_exec_pkg::op_io_read: begin
          rf_d = '{we: 1'b1, addr: issue_i.reg_idx, data: io_val};
        end
        cpu_exec_pkg::op_io_write: begin
          io_d = '{we: 1'b1, addr: issue_i.io_addr, data: reg_val};
        end
        cpu_exec_pkg::op_push: begin
          dmem_d  = '{req: 1'b1, we: 1'b1, lock: 1'b0, addr: sp_q, wdata: reg_val};
          sp_d    = sp_q - 16'h0001;
          state_d = cpu_exec_pkg::ST_WRITE;
          done_d  = 1'b0;
        end
        cpu_exec_pkg::op_pop: begin
          dmem_d  = '{req: 1'b1, we: 1'b0, lock: 1'b0, addr: sp_q + 16'h0001, wdata: 8'h00};
          sp_d    = sp_q + 16'h0001;
          state_d = cpu_exec_pkg::ST_READ;
          done_d  = 1'b0;
        end
        cpu_exec_pkg::op_ram_exchange_op, cpu_exec_pkg::op_ram_load_or_op,
        cpu_exec_pkg::op_ram_load_clearbits_op, cpu_exec_pkg::op_ram_load_xor_op: begin
          dmem_d  = '{req: 1'b1, we: 1'b0, lock: 1'b1, addr: z_ptr_i, wdata: 8'h00};
          state_d = cpu_exec_pkg::ST_READ;
          done_d  = 1'b0;
        end
        cpu_exec_pkg::op_shift_left_logical, cpu_exec_pkg::op_carry_rotate_left,
        cpu_exec_pkg::op_shift_right_logical, cpu_exec_pkg::op_carry_rotate_right,
        cpu_exec_pkg::op_shift_right_signed: begin
          rf_d = '{we: 1'b1, addr: issue_i.reg_idx, data: sh_res};
          flags_d[cpu_exec_pkg::FLAG_C] = sh_c;
          flags_d[cpu_exec_pkg::FLAG_Z] = (sh_res == 8'h00);
          flags_d[cpu_exec_pkg::FLAG_N] = sh_res[7];
          flags_d[cpu_exec_pkg::FLAG_V] = sh_res[7] ^ sh_c;
          if (sh_left) begin
            flags_d[cpu_exec_pkg::FLAG_H] = reg_val[3];
          end
        end
        cpu_exec_pkg::op_flag_select_set:   flags_d[issue_i.bit_sel] = 1'b1;
        cpu_exec_pkg::op_flag_select_clear: flags_d[issue_i.bit_sel] = 1'b0;
        cpu_exec_pkg::op_io_bit_force_one: begin
          io_d = '{we: 1'b1, addr: issue_i.io_addr, data: io_val | bit_mask};
        end
        cpu_exec_pkg::op_io_bit_force_zero: begin
          io_d = '{we: 1'b1, addr: issue_i.io_addr, data: io_val & ~bit_mask};
        end
        cpu_exec_pkg::op_reg_bit_to_tflag: begin
          flags_d[cpu_exec_pkg::FLAG_T] = reg_val[issue_i.bit_sel];
        end
        cpu_exec_pkg::op_tflag_to_reg_bit: begin
          rf_d.we   = 1'b1;
          rf_d.addr = issue_i.reg_idx;
          rf_d.data = flags_q[cpu_exec_pkg::FLAG_T] ? (reg_val | bit_mask) : (reg_val & ~bit_mask);
        end
        cpu_exec_pkg::op_sleep:               sleep_d = 1'b1;
        cpu_exec_pkg::op_break:               brk_d   = 1'b1;
        cpu_exec_pkg::op_watchdog_restart_op: wdt_d   = 1'b1;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave decode
  // ----------------------------------------------------------------
  // Writes land on the edge that the master samples ack, as it expects
  wire       bus_req  = wb_cyc_i & wb_stb_i;
  wire [7:0] bus_off  = 8'(wb_adr_i);
  wire       bus_wr   = bus_req & wb_we_i & ack_q;
  wire       wr_ctrl  = bus_wr & (bus_off == cpu_exec_pkg::CTRL_OFF) & wb_sel_i[0];
  wire       wr_sp_lo = bus_wr & (bus_off == cpu_exec_pkg::SP_OFF) & wb_sel_i[0];
  wire       wr_sp_hi = bus_wr & (bus_off == cpu_exec_pkg::SP_OFF) & wb_sel_i[1];
  wire [15:0] sp_bus  = {wr_sp_hi ? wb_dat_i[15:8] : sp_d[15:8], wr_sp_lo ? wb_dat_i[7:0] : sp_d[7:0]};
  wire [31:0] state_word = {26'h0, dmem_q.lock, dmem_q.req, 2'b00, state_q};

  // Read mux; unmapped words read as zero
  logic [31:0] rd_mux;
  always_comb begin
    unique case (bus_off)
      cpu_exec_pkg::CTRL_OFF:  rd_mux = {31'h0, en_q};
      cpu_exec_pkg::SP_OFF:    rd_mux = {16'h0, sp_q};
      cpu_exec_pkg::FLAGS_OFF: rd_mux = {24'h0, flags_q};
      cpu_exec_pkg::STATE_OFF: rd_mux = state_word;
      default:                 rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Bus write to the stack pointer overrides a push or pop in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= cpu_exec_pkg::ST_IDLE;
      hold_q  <= '0;
      dmem_q  <= '0;
      io_q    <= '0;
      rf_q    <= '0;
      sp_q    <= cpu_exec_pkg::SP_RST;
      flags_q <= cpu_exec_pkg::FLAGS_RST;
      done_q  <= 1'b0;
      sleep_q <= 1'b0;
      brk_q   <= 1'b0;
      wdt_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_q  <= hold_d;
      dmem_q  <= dmem_d;
      io_q    <= io_d;
      rf_q    <= rf_d;
      sp_q    <= sp_bus;
      flags_q <= flags_d;
      done_q  <= done_d;
      sleep_q <= sleep_d;
      brk_q   <= brk_d;
      wdt_q   <= wdt_d;
    end
  end

  // Bus slave flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q   <= cpu_exec_pkg::CTRL_EN_RST;
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= bus_req & ~ack_q;
      rdat_q <= rd_mux;
      if (wr_ctrl) begin
        en_q <= wb_dat_i[cpu_exec_pkg::CTRL_EN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign done_o         = done_q;
  assign rf_wr_o        = rf_q;
  assign io_wr_o        = io_q;
  assign dmem_o         = dmem_q;
  assign status_flags_o = flags_q;
  assign sleep_req_o    = sleep_q;
  assign break_req_o    = brk_q;
  assign wdt_restart_o  = wdt_q;
  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = rdat_q;

endmodule

// File: verification/dmem_model.sv
// Data memory model, 256 bytes mirrored.
// Answers at once, or after one wait when slow_i is high.
`timescale 1ns/1ps
module dmem_model (
  input  wire logic                    clk_i,
  input  wire logic                    slow_i,
  input  wire cpu_exec_pkg::dmem_req_t req_i,
  output logic                         ack_o,
  output logic [7:0]                   rdata_o
);
  logic [7:0] mem_q[256];
  logic       wt_q;
  // Data bus shows garbage outside an answer
  assign ack_o   = req_i.req & (~slow_i | wt_q);
  assign rdata_o = ack_o ? mem_q[req_i.addr[7:0]] : ~mem_q[req_i.addr[7:0]];
  // Writes land only at the answering edge
  always @(posedge clk_i) begin
    wt_q <= req_i.req & ~ack_o;
    if (ack_o & req_i.we) mem_q[req_i.addr[7:0]] <= req_i.wdata;
  end
  initial foreach (mem_q[j]) mem_q[j] = 8'(j) ^ 8'h5a;
endmodule

// File: verification/cpu_io_bit_flag_exec_asserts.sv
// Port checks of the execution unit.
// Assumes binding onto the unit's top.
`timescale 1ns/1ps
module cpu_io_bit_flag_exec_asserts (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    issue_valid_i,
  input wire logic                    issue_ready_o,
  input wire cpu_exec_pkg::issue_t    issue_i,
  input wire logic [7:0]              rf_rdata_i,
  input wire logic [7:0]              io_rdata_i,
  input wire cpu_exec_pkg::io_wr_t    io_wr_o,
  input wire cpu_exec_pkg::dmem_req_t dmem_o,
  input wire logic                    dmem_ack_i,
  input wire logic [7:0]              status_flags_o,
  input wire logic                    sleep_req_o,
  input wire logic                    break_req_o,
  input wire logic                    wdt_restart_o
);
  logic [5:0] op;
  // Op taken this cycle, else an unused code
  assign op = (issue_valid_i & issue_ready_o) ? issue_i.op : 6'h3f;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_iow; op == 6'h02 |=> io_wr_o.we && io_wr_o.data == $past(rf_rdata_i); endproperty
  a_iow: assert property (p_iow) else $error("io write data");
  property p_one; op == 6'h10 |=> io_wr_o.data == ($past(io_rdata_i) | 8'h01 << $past(issue_i.bit_sel)); endproperty
  a_one: assert property (p_one) else $error("bit set");
  property p_zro; op == 6'h11 |=> io_wr_o.data == ($past(io_rdata_i) & ~(8'h01 << $past(issue_i.bit_sel))); endproperty
  a_zro: assert property (p_zro) else $error("bit clear");
  property p_psh; op == 6'h03 |=> dmem_o.req && dmem_o.we && dmem_o.wdata == $past(rf_rdata_i); endproperty
  a_psh: assert property (p_psh) else $error("push");
  property p_pop; op == 6'h04 |=> dmem_o.req && !dmem_o.we ##0 $stable(status_flags_o); endproperty
  a_pop: assert property (p_pop) else $error("pop");
  property p_lck; dmem_o.req && dmem_o.lock && !dmem_o.we && dmem_ack_i |=>
    (dmem_o.req && dmem_o.we && dmem_o.lock) or
    (!dmem_o.req && dmem_o.lock ##1 dmem_o.req && dmem_o.we && dmem_o.lock); endproperty
  a_lck: assert property (p_lck) else $error("lock");
  property p_wdr; op == 6'h26 |=> wdt_restart_o && $stable(status_flags_o); endproperty
  a_wdr: assert property (p_wdr) else $error("watchdog");
  property p_slp; op == 6'h24 |=> sleep_req_o ##1 !sleep_req_o; endproperty
  a_slp: assert property (p_slp) else $error("sleep");
  property p_brk; op == 6'h25 |=> break_req_o; endproperty
  a_brk: assert property (p_brk) else $error("break");
endmodule
bind cpu_io_bit_flag_exec cpu_io_bit_flag_exec_asserts u_asserts (.*);

// File: verification/test_cpu_io_bit_flag_exec.sv
// Bench: every op with prompt, then slow memory, plus bus access.
// Assumes package, unit, memory model and checker compiled first.
`timescale 1ns/1ps
module test_cpu_io_bit_flag_exec;
  logic        clk_i = 0, rst_i = 1, issue_valid_i = 0, slow = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic        issue_ready_o, done_o, dmem_ack_i, wb_ack_o, sleep_req_o, break_req_o, wdt_restart_o;
  logic [7:0]  rf_rdata_i = 0, io_rdata_i = 0, wb_adr_i = 0, dmem_rdata_i, status_flags_o, fl = 0, sh[256];
  logic [15:0] z_ptr_i = 0, sp = 16'h0fff;
  logic [4:0]  rf_raddr_o;
  logic [5:0]  io_raddr_o;
  logic [31:0] wb_dat_i = 0, wb_dat_o, seed = 32'h0b20afd6;
  logic [9:0]  exp_q[$];
  int          fail_count = 0, checked = 0;
  byte         fm[8] = '{0, 2, 1, 7, 4, 3, 6, 5};
  cpu_exec_pkg::issue_t    issue_i = '0;
  cpu_exec_pkg::rf_wr_t    rf_wr_o;
  cpu_exec_pkg::io_wr_t    io_wr_o;
  cpu_exec_pkg::dmem_req_t dmem_o;
  always #25 clk_i = ~clk_i;
  cpu_io_bit_flag_exec u_cpu_io_bit_flag_exec (.*, .wb_sel_i(4'hf));
  dmem_model u_dmem_model (.clk_i, .slow_i(slow), .req_i(dmem_o), .ack_o(dmem_ack_i), .rdata_o(dmem_rdata_i));
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(logic [31:0] got, logic [31:0] want);
    checked++;
    if (got !== want) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic results();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Issue one op and note every write and the final flags
  task automatic run(int i);
    logic [7:0] r, v, m, a, vr, vi, vm;
    logic [5:0] o;
    logic [2:0] b, e;
    logic       c;
    seed = nx(seed);
    {r, v, b} = seed[18:0];
    {o, m, c, e} = {6'(i), sh[v], fl[0], 3'd0};
    if (o == 6'h04) sp++;
    case (o)
      6'h01: {e, vr} = {3'd1, ~r};
      6'h02: {e, vi} = {3'd2, r};
      6'h03: {e, vm, a} = {3'd4, r, sp[7:0]};
      6'h04: {e, vr} = {3'd1, sh[sp[7:0]]};
      6'h05: {e, vr, vm, a} = {3'd5, m, r, v};
      6'h06: {e, vr, vm, a} = {3'd5, m, r | m, v};
      6'h07: {e, vr, vm, a} = {3'd5, m, m & ~r, v};
      6'h08: {e, vr, vm, a} = {3'd5, m, r ^ m, v};
      6'h09, 6'h0b: {e, vr, fl[0], fl[5]} = {3'd1, r[6:0], o[1] & c, r[7], r[3]};
      6'h0a, 6'h0c, 6'h0d: {e, vr, fl[0]} = {3'd1, (o == 6'h0c) ? c : o[0] & r[7], r[7:1], r[0]};
      6'h0e, 6'h0f: fl[b] = ~o[0];
      6'h10: {e, vi} = {3'd2, ~r | 8'h01 << b};
      6'h11: {e, vi} = {3'd2, ~r & ~(8'h01 << b)};
      6'h12: fl[6] = r[b];
      6'h13: {e, vr} = {3'd1, fl[6] ? r | 8'h01 << b : r & ~(8'h01 << b)};
      default: if (o >= 6'h14 && o <= 6'h23) fl[fm[(o - 6'h14) >> 1]] = ~o[0];
    endcase
    if (o >= 6'h09 && o <= 6'h0d) fl[3:1] = {vr[7] ^ fl[0], vr[7], vr == 8'h00};
    if (o == 6'h03) sp--;
    if (e[2]) sh[a] = vm;
    if (e[0]) exp_q.push_back({2'd0, vr});
    if (e[1]) exp_q.push_back({2'd1, vi});
    if (e[2]) exp_q.push_back({2'd2, vm});
    exp_q.push_back({2'd3, fl});
    @(posedge clk_i);
    issue_i <= '{cpu_exec_pkg::op_t'(o), 5'h03, r[5:0], b, slow};
    {rf_rdata_i, io_rdata_i, issue_valid_i} <= {r, ~r, 1'b1};
    z_ptr_i <= (o == 6'h03) ? sp + 16'h0001 : (o == 6'h04) ? sp : {8'h00, v};
    do @(posedge clk_i); while (issue_ready_o !== 1'b1);
    issue_valid_i <= 0;
    do @(posedge clk_i); while (done_o !== 1'b1);
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (!w) cmp(wb_dat_o, d);
  endtask
  // Oldest note against each write or completion seen
  always @(posedge clk_i) if (!rst_i) begin
    if (rf_wr_o.we === 1'b1) cmp({2'd0, rf_wr_o.data}, exp_q.pop_front());
    if (io_wr_o.we === 1'b1) cmp({2'd1, io_wr_o.data}, exp_q.pop_front());
    if ((dmem_o.req & dmem_o.we & dmem_ack_i) === 1'b1) cmp({2'd2, dmem_o.wdata}, exp_q.pop_front());
    if (done_o === 1'b1) cmp({2'd3, status_flags_o}, exp_q.pop_front());
    if (rf_wr_o.we === 1'b1) cmp(rf_wr_o.addr, 5'h03);
    if (io_wr_o.we === 1'b1) cmp(io_wr_o.addr, issue_i.io_addr);
    if ((dmem_o.req & dmem_ack_i) === 1'b1) cmp(dmem_o.addr, z_ptr_i);
    if (issue_valid_i) cmp({rf_raddr_o, io_raddr_o}, {5'h03, issue_i.io_addr});
  end
  // Reset, all ops twice, then bus access
  initial begin
    foreach (sh[j]) sh[j] = 8'(j) ^ 8'h5a;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    for (int p = 0; p < 78; p++) begin
      if (p == 39) slow <= 1;
      run(p % 39);
    end
    wb(0, 8'h08, {24'h0, fl});
    wb(0, 8'h04, {16'h0, sp});
    wb(0, 8'h10, 0);
    wb(1, 8'h00, 0);
    @(negedge clk_i);
    cmp({31'h0, issue_ready_o}, 0);
    wb(1, 8'h00, 1);
    run(38);
    @(posedge clk_i);
    cmp(exp_q.size(), 0);
    results();
  end
  // Hang guard
  initial begin
    #100us;
    fail_count++;
    results();
  end
endmodule
